// >>> hdl/trig_params.svh
// constants for the trigger output selector: register offsets,
// field positions, reset values and the safe-boot switch code.
// assumes byte addresses on an 8-bit wishbone address bus.
`ifndef TRIG_PARAMS_SVH
`define TRIG_PARAMS_SVH

// ------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ------------------------------------------------------------
`define TRIG_ADR_CTRL 8'h00
`define TRIG_ADR_CMD 8'h04
`define TRIG_ADR_STATUS 8'h08

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define TRIG_CTRL_MODE_LSB 0
`define TRIG_CTRL_MODE_MSB 1
`define TRIG_CTRL_POL_BIT 2
`define TRIG_CTRL_SWO_BIT 3
`define TRIG_CMD_PERSIST_BIT 0
`define TRIG_CMD_DEFAULTS_BIT 1
`define TRIG_STAT_RUN_BIT 0
`define TRIG_STAT_SAFE_BIT 1
`define TRIG_STAT_PIN_BIT 2
`define TRIG_STAT_MOTION_BIT 3
`define TRIG_STAT_DONE_BIT 4
`define TRIG_STAT_MAXVEL_BIT 5
`define TRIG_STAT_PEND_BIT 6

// ------------------------------------------------------------
// reset and factory values
// ------------------------------------------------------------
`define TRIG_RST_POLARITY 1'b1
`define TRIG_RST_SWO 1'b0
`define TRIG_PIN_IDLE 1'b0
`define TRIG_SAFE_SWITCH_CODE 4'hD

`endif

// >>> hdl/trig_pkg.sv
// types shared by the trigger output selector and its bench.
// assumes nothing of its surroundings.
`default_nettype none

package trig_pkg;

	// ------------------------------------------------------------
	// condition selection
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_DISABLED,
		MODE_IN_MOTION,
		MODE_MOVE_DONE,
		MODE_MAX_VEL
	} trig_mode_e;

	// ------------------------------------------------------------
	// live and persisted records
	// ------------------------------------------------------------
	typedef struct packed {
		trig_mode_e mode;
		logic active_high;
		logic software_output_write;
	} trig_cfg_s;

	typedef struct packed {
		trig_cfg_s cfg;
		logic defaults_pending;
	} nv_rec_s;

	// ------------------------------------------------------------
	// boot sequence
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_CAPTURE,
		ST_WAIT_PHASE,
		ST_RUN
	} boot_state_e;

endpackage

`default_nettype wire

// >>> hdl/motion_trigger_output_select.sv
// trigger output selector with wishbone register access and a
// persistent settings port.
// assumes registered motion status from the trajectory generator,
// a non-volatile store that presents its record from power-up,
// and rst_i asserted once per power cycle.
//
// Added by the designer: the register offsets and register access over Wishbone.
`default_nettype none

`include "trig_params.svh"

// How it works
// - config picks motion, done or max-velocity condition
// - output asserted while condition holds, one clock behind it
// - one active level, high or low, shared by all conditions
// - persisted settings applied after phase init
// - disabled mode gives pin to software
// - max-velocity condition from constant-velocity status
// - move-complete condition asserts selected level
// - factory restore latched until next power cycle
// - switch at D boots defaults, persisting allowed
// - switch off D reloads last persisted settings
module motion_trigger_output_select (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic in_motion_i,
	input wire logic move_complete_i,
	input wire logic at_max_vel_i,
	input wire logic phase_init_done_i,
	input wire logic [3:0] channel_identity_switch_i,
	input wire trig_pkg::nv_rec_s nv_rdata_i,
	output logic nv_wr_o,
	output trig_pkg::nv_rec_s nv_wdata_o,
	output logic trigger_output_pin_o
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	trig_pkg::boot_state_e state;
	trig_pkg::trig_cfg_s cfg;
	trig_pkg::trig_cfg_s factory_cfg;
	trig_pkg::nv_rec_s boot_rec;
	logic safe_boot;
	logic defaults_pending;
	logic bus_req;
	logic bus_wr;
	logic bus_rd;
	logic ctrl_wr;
	logic cmd_wr;
	logic persist_req;
	logic restore_req;
	logic boot_apply;
	logic boot_use_defaults;
	logic cond;
	logic next_pin;
	logic [31:0] next_rdata;

	// ------------------------------------------------------------
	// factory settings
	// ------------------------------------------------------------

	// disabled, active high, software level low
	always_comb
	begin
		factory_cfg.mode = trig_pkg::MODE_DISABLED;
		factory_cfg.active_high = `TRIG_RST_POLARITY;
		factory_cfg.software_output_write = `TRIG_RST_SWO;
	end

	// ------------------------------------------------------------
	// wishbone decode
	// ------------------------------------------------------------

	// one request per ack, answered on the next edge
	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
	assign bus_rd = bus_req && !wb_we_i;

	// settings and commands are only taken once running
	assign ctrl_wr = bus_wr && (wb_adr_i == `TRIG_ADR_CTRL)
		&& (state == trig_pkg::ST_RUN);
	assign cmd_wr = bus_wr && (wb_adr_i == `TRIG_ADR_CMD)
		&& (state == trig_pkg::ST_RUN);
	assign persist_req = cmd_wr && wb_dat_i[`TRIG_CMD_PERSIST_BIT];
	assign restore_req = cmd_wr && wb_dat_i[`TRIG_CMD_DEFAULTS_BIT];

	// ------------------------------------------------------------
	// boot sequence
	// ------------------------------------------------------------

	// defaults win in safe boot or after a latched restore
	assign boot_apply = (state == trig_pkg::ST_WAIT_PHASE) && phase_init_done_i;
	assign boot_use_defaults = safe_boot || boot_rec.defaults_pending;

	// capture, wait for phase init, then run
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state <= trig_pkg::ST_CAPTURE;
		end
		else
		begin
			case (state)
				trig_pkg::ST_CAPTURE:
				begin
					state <= trig_pkg::ST_WAIT_PHASE;
				end
				trig_pkg::ST_WAIT_PHASE:
				begin
					if (phase_init_done_i)
					begin
						state <= trig_pkg::ST_RUN;
					end
				end
				trig_pkg::ST_RUN:
				begin
					state <= trig_pkg::ST_RUN;
				end
				default:
				begin
					state <= trig_pkg::ST_CAPTURE;
				end
			endcase
		end
	end

	// switch and stored record caught just after reset release
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			safe_boot <= 1'b0;
			boot_rec <= '0;
		end
		else if (state == trig_pkg::ST_CAPTURE)
		begin
			// switch away from D boots the stored record again
			safe_boot <= (channel_identity_switch_i == `TRIG_SAFE_SWITCH_CODE);
			boot_rec <= nv_rdata_i;
		end
	end

	// ------------------------------------------------------------
	// live configuration
	// ------------------------------------------------------------

	// loaded once phase init completes, then software owned
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cfg <= factory_cfg;
		end
		else if (boot_apply)
		begin
			if (boot_use_defaults)
			begin
				cfg <= factory_cfg;
			end
			else
			begin
				cfg <= boot_rec.cfg;
			end
		end
		else if (ctrl_wr)
		begin
			cfg.mode <= trig_pkg::trig_mode_e'(
				wb_dat_i[`TRIG_CTRL_MODE_MSB:`TRIG_CTRL_MODE_LSB]);
			cfg.active_high <= wb_dat_i[`TRIG_CTRL_POL_BIT];
			cfg.software_output_write <= wb_dat_i[`TRIG_CTRL_SWO_BIT];
		end
	end

	// ------------------------------------------------------------
	// deferred factory restore
	// ------------------------------------------------------------

	// latched here and in the store, never applied now
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			defaults_pending <= 1'b0;
		end
		else if (restore_req)
		begin
			defaults_pending <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// persistent store port
	// ------------------------------------------------------------

	// one-cycle write strobe with the record to keep
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			nv_wr_o <= 1'b0;
			nv_wdata_o <= '0;
		end
		else if (boot_apply && boot_rec.defaults_pending && !safe_boot)
		begin
			// restore consumed: store factory values, clear flag
			nv_wr_o <= 1'b1;
			nv_wdata_o.cfg <= factory_cfg;
			nv_wdata_o.defaults_pending <= 1'b0;
		end
		else if (restore_req)
		begin
			nv_wr_o <= 1'b1;
			nv_wdata_o.cfg <= cfg;
			nv_wdata_o.defaults_pending <= 1'b1;
		end
		else if (persist_req)
		begin
			// still allowed in safe boot
			nv_wr_o <= 1'b1;
			nv_wdata_o.cfg <= cfg;
			nv_wdata_o.defaults_pending <= defaults_pending;
		end
		else
		begin
			nv_wr_o <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// condition select and output pin
	// ------------------------------------------------------------

	// selected motion condition from registered status
	always_comb
	begin
		case (cfg.mode)
			trig_pkg::MODE_IN_MOTION:
			begin
				cond = in_motion_i;
			end
			trig_pkg::MODE_MOVE_DONE:
			begin
				cond = move_complete_i;
			end
			trig_pkg::MODE_MAX_VEL:
			begin
				// constant phase at the velocity_param_set maximum
				cond = at_max_vel_i;
			end
			default:
			begin
				cond = 1'b0;
			end
		endcase
	end

	// level for the pin on the next edge
	always_comb
	begin
		if (state != trig_pkg::ST_RUN)
		begin
			next_pin = `TRIG_PIN_IDLE;
		end
		else if (cfg.mode == trig_pkg::MODE_DISABLED)
		begin
			next_pin = cfg.software_output_write;
		end
		else if (cfg.active_high)
		begin
			next_pin = cond;
		end
		else
		begin
			next_pin = !cond;
		end
	end

	// pin registered, one clock behind the status inputs
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			trigger_output_pin_o <= `TRIG_PIN_IDLE;
		end
		else
		begin
			trigger_output_pin_o <= next_pin;
		end
	end

	// ------------------------------------------------------------
	// register read mux
	// ------------------------------------------------------------

	// unmapped offsets read as zero
	always_comb
	begin
		next_rdata = '0;
		case (wb_adr_i)
			`TRIG_ADR_CTRL:
			begin
				next_rdata[`TRIG_CTRL_MODE_MSB:`TRIG_CTRL_MODE_LSB] = cfg.mode;
				next_rdata[`TRIG_CTRL_POL_BIT] = cfg.active_high;
				next_rdata[`TRIG_CTRL_SWO_BIT] = cfg.software_output_write;
			end
			`TRIG_ADR_CMD:
			begin
				next_rdata[`TRIG_CMD_DEFAULTS_BIT] = defaults_pending;
			end
			`TRIG_ADR_STATUS:
			begin
				next_rdata[`TRIG_STAT_RUN_BIT] = (state == trig_pkg::ST_RUN);
				next_rdata[`TRIG_STAT_SAFE_BIT] = safe_boot;
				next_rdata[`TRIG_STAT_PIN_BIT] = trigger_output_pin_o;
				next_rdata[`TRIG_STAT_MOTION_BIT] = in_motion_i;
				next_rdata[`TRIG_STAT_DONE_BIT] = move_complete_i;
				next_rdata[`TRIG_STAT_MAXVEL_BIT] = at_max_vel_i;
				next_rdata[`TRIG_STAT_PEND_BIT] = defaults_pending;
			end
			default:
			begin
				next_rdata = '0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// wishbone answer
	// ------------------------------------------------------------

	// ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
		end
		else
		begin
			wb_ack_o <= bus_req;
		end
	end

	// read data registered with the ack, held otherwise
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_dat_o <= '0;
		end
		else if (bus_rd)
		begin
			wb_dat_o <= next_rdata;
		end
	end

endmodule

`default_nettype wire

// >>> bench/trig_props.sv
// assertions on the trigger output selector ports.
// assumes the bind below, one clock domain.
`default_nettype none
`include "trig_params.svh"
module trig_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic in_motion_i,
	input wire logic move_complete_i,
	input wire logic at_max_vel_i,
	input wire logic phase_init_done_i,
	input wire logic [3:0] channel_identity_switch_i,
	input wire trig_pkg::nv_rec_s nv_rdata_i,
	input wire logic nv_wr_o,
	input wire trig_pkg::nv_rec_s nv_wdata_o,
	input wire logic trigger_output_pin_o
);
	// ----
	// helpers
	// ----
	logic seen;
	logic req;
	logic rd;
	logic restore_cmd;
	logic [2:0] sts;
	// bus request and restore command seen at an edge
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign rd = req && !wb_we_i;
	assign restore_cmd = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == `TRIG_ADR_CMD)
		&& wb_dat_i[`TRIG_CMD_DEFAULTS_BIT];
	// motion status as one word for change detection
	assign sts = {in_motion_i, move_complete_i, at_max_vel_i};
	// phase init seen since reset
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			seen <= 1'h0;
		else if (phase_init_done_i)
			seen <= 1'h1;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ----
	// properties
	// ----
	property p_ack; req |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
	property p_nv_pulse; nv_wr_o |=> !nv_wr_o; endproperty
	a_nv_pulse: assert property (p_nv_pulse) else $error("store strobe held");
	property p_nv_hold; $changed(nv_wdata_o) |-> nv_wr_o; endproperty
	a_nv_hold: assert property (p_nv_hold) else $error("store data moved");
	property p_restore;
		$past(restore_cmd) && nv_wr_o |-> nv_wdata_o.defaults_pending;
	endproperty
	a_restore: assert property (p_restore) else $error("restore not pending");
	property p_pre_run; !seen |=> !trigger_output_pin_o; endproperty
	a_pre_run: assert property (p_pre_run) else $error("pin before run");
	property p_cause;
		$changed(trigger_output_pin_o) |-> $past(wb_ack_o) || $past(phase_init_done_i)
			|| ($past(sts) != $past(sts, 2));
	endproperty
	a_cause: assert property (p_cause) else $error("pin moved alone");
	property p_stat_pin;
		rd && wb_adr_i == `TRIG_ADR_STATUS
			|=> wb_dat_o[`TRIG_STAT_PIN_BIT] == $past(trigger_output_pin_o);
	endproperty
	a_stat_pin: assert property (p_stat_pin) else $error("status pin bit");
	property p_unmapped;
		rd && !(wb_adr_i inside {`TRIG_ADR_CTRL, `TRIG_ADR_CMD, `TRIG_ADR_STATUS})
			|=> wb_dat_o == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read");
endmodule
bind motion_trigger_output_select trig_props props (.*);
`default_nettype wire

// >>> bench/nv_store_model.sv
// settings store standing beside the selector.
// assumes the selector clock; keeps its record across resets.
`default_nettype none
module nv_store_model (
	input wire logic clk_i,
	input wire logic wr_i,
	input wire trig_pkg::nv_rec_s wdata_i,
	output trig_pkg::nv_rec_s rdata_o
);
	// ----
	// record, factory contents at power-on
	// ----
	trig_pkg::nv_rec_s rec = 5'h04;
	assign rdata_o = rec;
	// store on strobe only
	always @(posedge clk_i)
	begin
		if (wr_i)
			rec <= wdata_i;
	end
endmodule
`default_nettype wire

// >>> bench/tb.sv
// self-checking bench for the trigger output selector.
// assumes the store model and the bound checker.
`default_nettype none
`include "trig_params.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, ph = 1'h0;
	logic ack, pin, nv_wr;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0, sw = 4'h0;
	logic [31:0] wdat = 32'h0000_0000, rdat, r;
	logic [2:0] st = 3'h0; // max vel, done, motion
	trig_pkg::nv_rec_s nv_rd, nv_wd;
	int failures = 0, compares = 0, cycles = 0;
	motion_trigger_output_select dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .in_motion_i(st[0]), .move_complete_i(st[1]),
		.at_max_vel_i(st[2]), .phase_init_done_i(ph), .channel_identity_switch_i(sw),
		.nv_rdata_i(nv_rd), .nv_wr_o(nv_wr), .nv_wdata_o(nv_wd), .trigger_output_pin_o(pin));
	nv_store_model nv (.clk_i(clk_i), .wr_i(nv_wr), .wdata_i(nv_wd), .rdata_o(nv_rd));
	// ----
	// clock, timeout, helpers
	// ----
	initial
	begin
		forever #50 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			failures++;
			results();
		end
	end
	task automatic results;
	begin
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	begin
		compares++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	end
	endtask
	task automatic tick(input int n);
	begin
		repeat (n) @(posedge clk_i);
		#1;
	end
	endtask
	// one classic cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
	begin
		@(posedge clk_i);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hf;
		do
			@(posedge clk_i);
		while (ack !== 1'h1);
		r = rdat;
		cyc <= 1'h0;
		stb <= 1'h0;
		we <= 1'h0;
		tick(1);
	end
	endtask
	task automatic ctrl(input logic [1:0] m, input logic p, input logic s);
		wb(1'h1, `TRIG_ADR_CTRL, {28'h0, s, p, m});
	endtask
	task automatic stat(input logic [2:0] v);
	begin
		@(posedge clk_i);
		st <= v;
		tick(1);
	end
	endtask
	// power cycle with the given switch position
	task automatic boot(input logic [3:0] s);
	begin
		@(posedge clk_i);
		rst_i <= 1'h1;
		ph <= 1'h0;
		sw <= s;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'h0;
		tick(5);
		chk(pin, 0);
		@(posedge clk_i);
		ph <= 1'h1;
		tick(3);
	end
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_modes;
		logic [2:0] one;
	begin
		for (int m = 1; m < 4; m++)
			for (int p = 0; p < 2; p++)
			begin
				one = 3'h1 << (m - 1);
				ctrl(m[1:0], p[0], 1'h0);
				stat(one);
				chk(pin, p);
				stat(~one);
				tick(3);
				chk(pin, !p[0]);
			end
	end
	endtask
	task automatic t_soft;
	begin
		ctrl(2'h0, 1'h1, 1'h1);
		stat(3'h7);
		chk(pin, 1);
		ctrl(2'h0, 1'h0, 1'h0);
		chk(pin, 0);
	end
	endtask
	task automatic t_persist;
	begin
		ctrl(2'h1, 1'h0, 1'h0);
		stat(3'h0);
		wb(1'h1, `TRIG_ADR_CMD, 32'h0000_0001);
		chk(nv.rec, 5'h08);
		boot(4'h0);
		chk(pin, 1);
		wb(1'h1, `TRIG_ADR_CMD, 32'h0000_0002);
		chk(pin, 1);
		chk(nv.rec.defaults_pending, 1);
		boot(4'h0);
		chk(pin, 0);
		chk(nv.rec, 5'h04);
	end
	endtask
	task automatic t_safe;
	begin
		ctrl(2'h1, 1'h0, 1'h0);
		wb(1'h1, `TRIG_ADR_CMD, 32'h0000_0001);
		boot(4'hD);
		chk(pin, 0);
		chk(nv.rec, 5'h08);
		ctrl(2'h2, 1'h1, 1'h0);
		wb(1'h1, `TRIG_ADR_CMD, 32'h0000_0001);
		chk(nv.rec, 5'h14);
		stat(3'h2);
		boot(4'h0);
		chk(pin, 1);
	end
	endtask
	task automatic t_bus;
	begin
		wb(1'h0, `TRIG_ADR_STATUS, 32'h0000_0000);
		chk(r[`TRIG_STAT_RUN_BIT], 1);
		chk(r[`TRIG_STAT_PIN_BIT], 1);
		chk(r[`TRIG_STAT_SAFE_BIT], 0);
		chk(r[`TRIG_STAT_DONE_BIT], 1);
		wb(1'h0, `TRIG_ADR_CTRL, 32'h0000_0000);
		chk(r, 32'h0000_0006);
		// unmapped read after nonzero reads must clear the data
		wb(1'h0, 8'h0C, 32'h0000_0000);
		chk(r, 0);
	end
	endtask
	initial
	begin
		boot(4'h0);
		t_modes();
		t_soft();
		t_persist();
		t_safe();
		t_bus();
		results();
	end
endmodule
`default_nettype wire
